/* File: inc/spmp_regs.svh */
`ifndef SPMP_REGS_SVH
`define SPMP_REGS_SVH
// ==========================================
// Register byte addresses
`define SPMP_CTRL_ADDR   4'h0
`define SPMP_STAT_ADDR   4'h4
`define SPMP_DATA_ADDR   4'h8
// ==========================================
// Control register field positions
`define SPMP_CR_BAUD_LO  0
`define SPMP_CR_BAUD_HI  1
`define SPMP_CR_CLOCK_PHASE_SEL     2
`define SPMP_CR_CLOCK_POLARITY_SEL     3
`define SPMP_CR_MASTER_SELECT_BIT     4
`define SPMP_CR_SPE      6
`define SPMP_CR_IRQEN    7
// ==========================================
// Status register field positions
`define SPMP_SR_MASTER_FAULT_FLAG     4
`define SPMP_SR_WRITE_COLLISION_FLAG     6
`define SPMP_SR_DONE     7
// ==========================================
// Reset values and timing
`define SPMP_CR_RESET    8'h00
`define SPMP_DIV0        8'h01
`define SPMP_DIV1        8'h03
`define SPMP_DIV2        8'h0f
`define SPMP_DIV3        8'h3f
`define SPMP_BITS        4'h8
`endif

/* File: inc/spmp_pkg.sv */
// ==========================================
// Shared types
package spmp_pkg;
  typedef enum logic [1:0] {
    SPMP_IDLE,
    SPMP_RUN,
    SPMP_DONE
  } spmp_state_t;
endpackage

/* File: rtl/spmp_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Two-flop synchroniser per bit
module spmp_sync (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [2:0] d,
  output var  logic [2:0] q
);
  logic [2:0] meta_r;  // First stage, read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_bit
      // Two stages for one pin
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_r[gi] <= 1'b1;
          q[gi]      <= 1'b1;
        end else begin
          meta_r[gi] <= d[gi];
          q[gi]      <= meta_r[gi];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: rtl/spmp_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spmp_regs.svh"
// Operation
// - full duplex byte, MSB first
// - master drives clock, slave follows it
// - four master rates, slave to fCPU/2
// - master bits kept only while select high
// - master drives MOSI, samples MISO
// - slave samples MOSI, drives MISO
// - data write loads shifter, starts master
// - slave starts on first clock edge
// - eight clock pulses per byte
// - done flag sets, gated interrupt
// - received byte buffered for data reads
// - status access then data access clears
// - data writes blocked until status read
// - unselected slave stays off the bus
// - polarity sets idle clock level
// - polarity and phase choose capture edge
// - data leads capture edge by one
// - phase picks first or second edge
// - busy write dropped, collision flag set
// - select low as master faults
// - selected slave freezes data register
module spmp_core
  import spmp_pkg::*;
#(
  parameter logic [7:0] DIV0 = `SPMP_DIV0,
  parameter logic [7:0] DIV1 = `SPMP_DIV1,
  parameter logic [7:0] DIV2 = `SPMP_DIV2,
  parameter logic [7:0] DIV3 = `SPMP_DIV3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        cpu_irq_mask,
  output var  logic        irq,
  input  wire logic        sck_in,
  output var  logic        sck_out,
  output var  logic        sck_oe,
  input  wire logic        mosi_in,
  output var  logic        mosi_out,
  output var  logic        mosi_oe,
  input  wire logic        miso_in,
  output var  logic        miso_out,
  output var  logic        miso_oe,
  input  wire logic        ss_n
);
  // ==========================================
  // Pin synchronisers
  logic [2:0] pin_s;       // Synced sck, mosi, miso
  logic [2:0] pin_raw;     // Raw pin group
  logic       ssn_m_r;     // Select first stage
  logic       ssn_s_r;     // Select synced
  assign pin_raw = {sck_in, mosi_in, miso_in};
  spmp_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pin_raw),
    .q       (pin_s)
  );
  // Select is synced alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ssn_m_r <= 1'b1;
      ssn_s_r <= 1'b1;
    end else begin
      ssn_m_r <= ss_n;
      ssn_s_r <= ssn_m_r;
    end
  end
  // ==========================================
  // Registers and state
  logic [7:0]  ctrl_r;        // Control register
  logic        done_r;        // Transfer done flag
  logic        write_collision_flag_r;        // Write collision flag
  logic        master_fault_flag_r;        // Master fault flag
  logic        done_armed_r;  // Status seen with done set
  logic        write_collision_flag_armed_r;  // Status seen with collision set
  logic        master_fault_flag_armed_r;  // Status seen with fault set
  logic [7:0]  shift_r;       // Shift register
  logic [7:0]  rxbuf_r;       // Receive buffer
  logic [3:0]  edge_cnt_r;    // Edges into the byte
  logic        sck_prev_r;    // Last synced slave clock
  logic        din_r;         // Latched input bit
  logic [7:0]  div_r;         // Rate divider
  spmp_state_t st_r;          // Transfer state
  logic        mclk_r;        // Master internal clock phase
  logic        ap_valid_r;    // Data phase pending
  logic        ap_write_r;    // Latched write
  logic [3:0]  ap_addr_r;     // Latched address
  // ==========================================
  // Decode
  wire        clock_polarity_sel      = ctrl_r[`SPMP_CR_CLOCK_POLARITY_SEL];
  wire        clock_phase_sel      = ctrl_r[`SPMP_CR_CLOCK_PHASE_SEL];
  wire        is_master_select_bit   = ctrl_r[`SPMP_CR_MASTER_SELECT_BIT];
  wire        is_en     = ctrl_r[`SPMP_CR_SPE];
  wire [1:0]  baud      = {ctrl_r[`SPMP_CR_BAUD_HI], ctrl_r[`SPMP_CR_BAUD_LO]};
  wire        ap_take   = hsel && hready && htrans[1];
  wire        acc_ctrl  = ap_valid_r && (ap_addr_r == `SPMP_CTRL_ADDR);
  wire        acc_stat  = ap_valid_r && (ap_addr_r == `SPMP_STAT_ADDR);
  wire        acc_data  = ap_valid_r && (ap_addr_r == `SPMP_DATA_ADDR);
  wire        wr_ctrl   = acc_ctrl && ap_write_r;
  wire        wr_data   = acc_data && ap_write_r;
  wire        busy      = (st_r == SPMP_RUN);
  wire        slave_sel = is_en && !is_master_select_bit && !ssn_s_r;
  wire        mfault    = is_en && is_master_select_bit && !ssn_s_r;
  // a selected slave refuses loads, even before the first edge
  wire        wr_block  = busy || slave_sel;
  wire        wr_ok     = wr_data && !wr_block && !(done_r && !done_armed_r);
  wire        wr_coll   = wr_data && wr_block;
  wire        done_clr  = done_armed_r && acc_data;
  wire [7:0]  div_lim   = (baud == 2'h0) ? DIV0 :
                          (baud == 2'h1) ? DIV1 :
                          (baud == 2'h2) ? DIV2 : DIV3;
  wire        div_tick  = (div_r == div_lim);
  // Edge detection on the synced slave clock; master uses its own ticks
  wire        s_edge    = slave_sel && (pin_s[2] != sck_prev_r);
  wire        m_edge    = is_en && is_master_select_bit && busy && div_tick;
  wire        xedge     = s_edge || m_edge;
  // Leading edge has index 0; odd edges are trailing
  wire        lead      = !edge_cnt_r[0];
  wire        sample_e  = xedge && (lead != clock_phase_sel);
  wire        shift_e   = xedge && (lead == clock_phase_sel) && !(clock_phase_sel && edge_cnt_r == 4'h0);
  wire        last_e    = xedge && (edge_cnt_r == 4'hf);
  wire        din_pin   = is_master_select_bit ? pin_s[0] : pin_s[1];
  wire        done_set  = last_e;
  wire        done_nxt  = done_set || (done_r && !done_clr);
  // Status byte: done on 7, collision on 6, fault on 4
  wire [7:0]  stat_byte = {done_r, write_collision_flag_r, 1'b0, master_fault_flag_r, 4'h0};
  // ==========================================
  // Bus response, always ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 4'h0;
    end else begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr[3:0];
    end
  end
  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ap_take && !hwrite) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      case (haddr[3:0])
        `SPMP_CTRL_ADDR: hrdata <= {24'h0, ctrl_r};
        `SPMP_STAT_ADDR: hrdata <= {24'h0, stat_byte};
        `SPMP_DATA_ADDR: hrdata <= {24'h0, rxbuf_r};
        default:         hrdata <= 32'h0;
      endcase
    end
  end
  // ==========================================
  // Control register, fault forces bits low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `SPMP_CR_RESET;
    end else if (mfault) begin
      ctrl_r[`SPMP_CR_SPE]  <= 1'b0;
      ctrl_r[`SPMP_CR_MASTER_SELECT_BIT] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata[7:0];
      if (master_fault_flag_r && !master_fault_flag_armed_r) begin
        ctrl_r[`SPMP_CR_SPE]  <= 1'b0;
        ctrl_r[`SPMP_CR_MASTER_SELECT_BIT] <= 1'b0;
      end
    end
  end
  // ==========================================
  // Status flags: set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r       <= 1'b0;
      write_collision_flag_r       <= 1'b0;
      master_fault_flag_r       <= 1'b0;
      done_armed_r <= 1'b0;
      write_collision_flag_armed_r <= 1'b0;
      master_fault_flag_armed_r <= 1'b0;
    end else begin
      done_r       <= done_nxt;
      write_collision_flag_r       <= wr_coll || (write_collision_flag_r && !(write_collision_flag_armed_r && acc_data && !ap_write_r));
      master_fault_flag_r       <= mfault || (master_fault_flag_r && !(master_fault_flag_armed_r && wr_ctrl));
      done_armed_r <= done_nxt && (done_armed_r || (acc_stat && done_r)) && !done_clr;
      write_collision_flag_armed_r <= (write_collision_flag_armed_r || (acc_stat && write_collision_flag_r)) && !(acc_data && !ap_write_r);
      master_fault_flag_armed_r <= (master_fault_flag_armed_r || (acc_stat && master_fault_flag_r)) && !wr_ctrl;
    end
  end
  // Interrupt from done or fault, gated by the CPU mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl_r[`SPMP_CR_IRQEN] && !cpu_irq_mask && (done_r || master_fault_flag_r);
    end
  end
  // ==========================================
  // Rate divider for master clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 8'h0;
    end else if (!busy || div_tick) begin
      div_r <= 8'h0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  // ==========================================
  // Transfer state and edge count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= SPMP_IDLE;
      edge_cnt_r <= 4'h0;
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= slave_sel ? pin_s[2] : clock_polarity_sel;
      case (st_r)
        SPMP_IDLE: begin
          edge_cnt_r <= 4'h0;
          if (wr_ok && is_en && is_master_select_bit) begin
            st_r <= SPMP_RUN;
          end else if (s_edge) begin
            st_r       <= SPMP_RUN;
            edge_cnt_r <= 4'h1;
          end
        end
        SPMP_RUN: begin
          if (!is_en || (!is_master_select_bit && ssn_s_r)) begin
            st_r <= SPMP_IDLE;
          end else if (last_e) begin
            st_r <= SPMP_DONE;
          end else if (xedge) begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
          end
        end
        SPMP_DONE: begin
          st_r <= SPMP_IDLE;
        end
        default: st_r <= SPMP_IDLE;
      endcase
    end
  end
  // ==========================================
  // Shift register: load, sample, shift MSB first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= 8'h0;
      din_r   <= 1'b0;
      rxbuf_r <= 8'h0;
    end else begin
      if (wr_ok) begin
        shift_r <= hwdata[7:0];
      end else if (shift_e) begin
        shift_r <= {shift_r[6:0], din_r};
      end
      if (sample_e) begin
        din_r <= din_pin;
      end
      if (last_e) begin
        rxbuf_r <= clock_phase_sel ? {shift_r[6:0], din_pin} : {shift_r[6:0], din_r};
      end
    end
  end
  // ==========================================
  // Pin drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mclk_r   <= 1'b0;
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      mclk_r   <= (busy && is_master_select_bit) ? (m_edge ? !mclk_r : mclk_r) : 1'b0;
      sck_out  <= clock_polarity_sel ^ mclk_r;
      sck_oe   <= is_en && is_master_select_bit;
      mosi_out <= shift_r[7];
      mosi_oe  <= is_en && is_master_select_bit;
      miso_out <= shift_r[7];
      miso_oe  <= slave_sel && (busy || !clock_phase_sel);
    end
  end
  // ==========================================
  // Checks
  chk_fault_clears_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    mfault |=> !ctrl_r[`SPMP_CR_MASTER_SELECT_BIT] && !ctrl_r[`SPMP_CR_SPE] && master_fault_flag_r)
    else $error("fault did not drop master mode");
  chk_busy_write_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_data && busy && !shift_e) |=> write_collision_flag_r && $stable(shift_r))
    else $error("collision write not flagged");
  chk_done_on_last: assert property (@(posedge hclk) disable iff (!hresetn)
    last_e |=> done_r && st_r == SPMP_DONE)
    else $error("done flag missed at byte end");
  chk_rx_buffer: assert property (@(posedge hclk) disable iff (!hresetn)
    !last_e |=> $stable(rxbuf_r))
    else $error("receive buffer changed mid byte");
  chk_done_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (done_r && !done_armed_r) |=> done_r)
    else $error("done cleared without status access");
  chk_write_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_data && done_r && !done_armed_r && !busy) |=> st_r == SPMP_IDLE)
    else $error("write accepted while done pending");
  chk_master_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ok && is_en && is_master_select_bit && !mfault) |=> busy && shift_r == $past(hwdata[7:0]))
    else $error("master write did not start");
  chk_idle_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == SPMP_IDLE) [*3] |-> sck_out == $past(clock_polarity_sel))
    else $error("idle clock level wrong");
  // Master clock edges counted apart from the edge counter
  logic [4:0]  m_tog_r;       // Master edges in this byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_tog_r <= 5'h00;
    end else if (st_r == SPMP_IDLE) begin
      m_tog_r <= 5'h00;
    end else if (m_edge) begin
      m_tog_r <= m_tog_r + 5'h01;
    end
  end
  chk_edge_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == SPMP_DONE && is_master_select_bit) |-> m_tog_r == 5'h10)
    else $error("master byte edge count wrong");
  chk_unselected_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!is_master_select_bit && ssn_s_r) |=> !miso_oe)
    else $error("unselected slave drove data");
endmodule
`default_nettype wire

/* File: tb/spmp_peer.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Far-side serial slave, behavioural
module spmp_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  logic [7:0] sh;  // Outgoing shifter
  initial miso = 1'b0;
  // Load on select; with phase clear the first bit goes out at once
  always @(negedge sel_n) begin
    sh = tx;
    if (!pha) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
  // A released line shows the inverse of its last value
  always @(posedge sel_n) miso = ~miso;
  // Capture on the chosen edge, present the next bit on the other
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != pol) ^ pha) begin
        rx = {rx[6:0], mosi};
      end else begin
        miso = sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/spi_master_slave_port_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spmp_regs.svh"
// ==========================================
// Bench top
module spi_master_slave_port_tb_top;
  localparam logic [3:0] a_ctl = `SPMP_CTRL_ADDR;  // Control offset
  localparam logic [3:0] a_sta = `SPMP_STAT_ADDR;  // Status offset
  localparam logic [3:0] a_dat = `SPMP_DATA_ADDR;  // Data offset
  localparam logic [7:0] s_tx  = 8'h6b;            // Byte sent by the bench master
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_irq_mask, irq, ss_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        bsck, bmosi, psel_n, pol, pha, p_miso;
  logic [7:0]  ptx, prx, got;
  int          fail_count, comparisons, edges, cycles;
  time         t0, t1;
  // Resolved pin levels
  wire logic   sck_w  = sck_oe ? sck_out : bsck;
  wire logic   mosi_w = mosi_oe ? mosi_out : bmosi;
  wire logic   miso_w = miso_oe ? miso_out : p_miso;
  // ==========================================
  // Design and far side
  spmp_core #(.DIV0(8'h03), .DIV1(8'h04), .DIV2(8'h05), .DIV3(8'h06)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_irq_mask(cpu_irq_mask), .irq(irq), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n(ss_n));
  spmp_peer peer (.sck(sck_w), .mosi(mosi_w), .sel_n(psel_n), .pol(pol), .pha(pha),
    .tx(ptx), .miso(p_miso), .rx(prx));
  // ==========================================
  // Clock, timeout and serial clock edge log
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  always @(sck_out) begin
    if (edges == 0) t0 = $time;
    if (edges == 1) t1 = $time;
    edges++;
  end
  // ==========================================
  // Bus tasks
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    haddr  <= {28'h0000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk(32'({hresp, hreadyout}), 32'h1);  // OKAY response, no wait
  endtask
  // Wait for eight serial clock pulses, then let the flags land
  task automatic wait_byte();
    repeat (400) if (edges < 16) @(posedge hclk);
    repeat (6) @(posedge hclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cpu_irq_mask = 1'b0;
    ss_n = 1'b1;
    bsck = 1'b0;
    bmosi = 1'b0;
    psel_n = 1'b1;
    pol = 1'b0;
    pha = 1'b0;
    ptx = 8'h00;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(a_ctl, 32'h0);
    rchk(a_sta, 32'h0);
    rchk(4'hc, 32'h0);
    // Master bytes in all four timing modes and all four rates
    for (int m = 0; m < 4; m++) begin
      pol <= m[1];
      pha <= m[0];
      ptx <= 8'h96 ^ 8'(m);
      bus(1'b1, a_ctl, 32'(8'hd0 | {4'h0, m[1:0], m[1:0]}));
      repeat (2) @(posedge hclk);
      chk(32'(sck_out), 32'(m[1]));
      psel_n <= 1'b0;
      edges = 0;
      @(posedge hclk);
      bus(1'b1, a_dat, 32'h3c + m);
      bus(1'b1, a_dat, 32'hff);
      repeat (400) if (irq !== 1'b1) @(posedge hclk);
      chk(32'(irq), 32'h1);
      chk(32'(edges), 32'd16);
      chk(32'(t1 - t0), 32'((m + 4) * 100));
      chk(32'(prx), 32'h3c + m);
      rchk(a_sta, 32'hc0);
      rchk(a_dat, 32'h96 ^ m);
      rchk(a_sta, 32'h0);
      psel_n <= 1'b1;
    end
    // Writes held off while done stands, masked interrupt
    cpu_irq_mask <= 1'b1;
    pol <= 1'b0;
    pha <= 1'b0;
    bus(1'b1, a_ctl, 32'hd0);
    repeat (2) @(posedge hclk);  // Keep the polarity change out of the edge log
    psel_n <= 1'b0;
    edges = 0;
    bus(1'b1, a_dat, 32'h55);
    wait_byte();
    chk(32'(irq), 32'h0);
    edges = 0;
    bus(1'b1, a_dat, 32'h77);
    repeat (20) @(posedge hclk);
    chk(32'(edges), 32'h0);
    rchk(a_sta, 32'h80);
    bus(1'b1, a_dat, 32'h77);
    wait_byte();
    chk(32'(prx), 32'h77);
    rchk(a_sta, 32'h80);
    bus(1'b0, a_dat, 32'h0);
    psel_n <= 1'b1;
    cpu_irq_mask <= 1'b0;
    // Select pulled low while master
    bus(1'b1, a_ctl, 32'hd0);
    ss_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(32'(irq), 32'h1);
    rchk(a_sta, 32'h10);
    rchk(a_ctl, 32'h80);
    ss_n <= 1'b1;
    bus(1'b1, a_ctl, 32'h0);
    rchk(a_sta, 32'h0);
    // Slave byte from a bench master, 800 ns serial clock
    bus(1'b1, a_ctl, 32'h47);
    bus(1'b1, a_dat, 32'ha5);
    ss_n <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(1'b1, a_dat, 32'h11);
    for (int i = 7; i >= 0; i--) begin
      bmosi <= s_tx[i];
      bsck <= 1'b1;
      repeat (4) @(posedge hclk);
      bsck <= 1'b0;
      repeat (2) @(posedge hclk);
      got[i] = miso_w;
      if (i == 0) chk(32'({miso_oe, sck_oe, mosi_oe}), 32'h4);
      repeat (2) @(posedge hclk);
    end
    repeat (8) @(posedge hclk);
    ss_n <= 1'b1;
    chk(32'(got), 32'ha5);
    rchk(a_sta, 32'hc0);
    rchk(a_dat, 32'(s_tx));
    report_and_stop();
  end
endmodule
`default_nettype wire
